//--- core/lwdt_core.sv
// 24-bit watchdog with byte-wide I/O registers behind the host I/O decoder.
// Assumes the decoder delivers one-cycle strobes with a 3-bit offset, and a
// one-cycle strobe for any write to the debug port 80h.
// The 80h strobe and its enable come from logic on this clock, so neither
// passes a synchroniser.
`timescale 1ns/1ps
`include "lwdt_params.svh"

module lwdt_core (
  input wire logic clk,
  input wire logic rst,
  input wire lwdt_pkg::lwdt_io_req_t io_req,
  input wire logic port80_wr,
  input wire logic port80_en,
  output logic [7:0] io_rdata,
  output logic irq,
  output logic module_rst
);

  // ==========================================================================
  // State
  logic [23:0] count_r;
  logic [23:0] reload_r;
  lwdt_pkg::lwdt_ctrl_t ctrl_r;
  logic first_flag_r;
  logic second_flag_r;
  logic [10:0] div_r;
  logic tick_r;

  logic wr_count;
  logic wr_flags;
  logic restart;
  logic expire;

  assign wr_count = io_req.wr && (io_req.addr <= `LWDT_OFF_COUNT_HIGH);
  assign wr_flags = io_req.wr && (io_req.addr == `LWDT_OFF_FLAGS);
  assign restart = wr_count || (port80_wr && port80_en);
  // Expiry is the tick that finds the counter at one or at zero
  assign expire = ctrl_r.countdown_enable && tick_r && !restart
    && (count_r <= 24'h000001);

  // ==========================================================================
  // Tick divider, free-running, so interval jitter after a restart is up to one tick
  localparam logic [10:0] TICK_LAST = 11'(`LWDT_TICK_DIV - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TICK_LAST);
      div_r <= (div_r == TICK_LAST) ? 11'h000 : div_r + 11'h001;
    end
  end

  // ==========================================================================
  // Running counter
  // Restart outranks expiry, so a kick on the last tick still counts
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= `LWDT_RST_COUNT;
    end else if (restart) begin
      count_r <= reload_r;
    end else if (expire) begin
      count_r <= reload_r;
    end else if (ctrl_r.countdown_enable && tick_r) begin
      count_r <= count_r - 24'h000001;
    end
  end

  // ==========================================================================
  // Reload value
  // Bytes land one at a time; write all three before restarting
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_r <= `LWDT_RST_RELOAD;
    end else if (io_req.wr) begin
      if (io_req.addr == `LWDT_OFF_RELOAD_LOW) begin
        reload_r[7:0] <= io_req.wdata;
      end else if (io_req.addr == `LWDT_OFF_RELOAD_MID) begin
        reload_r[15:8] <= io_req.wdata;
      end else if (io_req.addr == `LWDT_OFF_RELOAD_HIGH) begin
        reload_r[23:16] <= io_req.wdata;
      end
    end
  end

  // ==========================================================================
  // Control register
  // Reserved bits 7:2 are dropped on write
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `LWDT_RST_CTRL;
    end else if (io_req.wr && io_req.addr == `LWDT_OFF_CONTROL) begin
      ctrl_r.countdown_enable <= io_req.wdata[`LWDT_BIT_CNT_EN];
      ctrl_r.module_reset_enable <=
        io_req.wdata[`LWDT_BIT_RST_EN];
    end
  end

  // ==========================================================================
  // Expiry flags; a set in the clearing cycle wins
  logic clr_first;
  logic clr_second;
  logic set_first;
  logic set_second;

  assign clr_first = (wr_flags && io_req.wdata[`LWDT_BIT_FIRST])
    || (port80_wr && port80_en);
  assign clr_second = wr_flags
    && io_req.wdata[`LWDT_BIT_SECOND];
  assign set_first = expire && !first_flag_r;
  assign set_second = expire && first_flag_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      first_flag_r <= 1'b0;
    end else if (set_first) begin
      first_flag_r <= 1'b1;
    end else if (clr_first) begin
      first_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      second_flag_r <= 1'b0;
    end else if (set_second) begin
      second_flag_r <= 1'b1;
    end else if (clr_second) begin
      second_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt and module reset pulses
  // Expiry only comes on a tick, so pulses never repeat back to back
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      module_rst <= 1'b0;
    end else begin
      // Second expiry raises the interrupt only when reset is not taken
      irq <= set_first
        || (set_second && !ctrl_r.module_reset_enable);
      module_rst <= set_second
        && ctrl_r.module_reset_enable;
    end
  end

  // ==========================================================================
  // Read data, registered so the output comes from a flip-flop
  // Reserved bits read back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd) begin
      if (io_req.addr == `LWDT_OFF_COUNT_LOW) begin
        io_rdata <= count_r[7:0];
      end else if (io_req.addr == `LWDT_OFF_COUNT_MID) begin
        io_rdata <= count_r[15:8];
      end else if (io_req.addr == `LWDT_OFF_COUNT_HIGH) begin
        io_rdata <= count_r[23:16];
      end else if (io_req.addr == `LWDT_OFF_RELOAD_LOW) begin
        io_rdata <= reload_r[7:0];
      end else if (io_req.addr == `LWDT_OFF_RELOAD_MID) begin
        io_rdata <= reload_r[15:8];
      end else if (io_req.addr == `LWDT_OFF_RELOAD_HIGH) begin
        io_rdata <= reload_r[23:16];
      end else if (io_req.addr == `LWDT_OFF_FLAGS) begin
        io_rdata <= {5'h00, second_flag_r, 1'b0, first_flag_r};
      end else begin
        io_rdata <= {6'h00, ctrl_r.countdown_enable,
          ctrl_r.module_reset_enable};
      end
    end
  end

  // ==========================================================================
  // Checks, all on the one clock and quiet during reset
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Tick spacing monitor; read only by the period check
  logic [10:0] gap_r;
  logic seen_tick_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= 11'h000;
      seen_tick_r <= 1'b0;
    end else if (tick_r) begin
      gap_r <= 11'h000;
      seen_tick_r <= 1'b1;
    end else begin
      // Never wraps: the next tick comes first
      gap_r <= gap_r + 11'h001;
    end
  end

  a_tick_space: assert property (
    tick_r |=> !tick_r [*8])
    else $error("ticks too close");
  a_tick_period: assert property (
    tick_r && seen_tick_r |-> gap_r == TICK_LAST)
    else $error("tick period wrong");

  // ==========================================================================
  // Counter and register checks
  a_stop_holds: assert property (
    !ctrl_r.countdown_enable && !restart |=> $stable(count_r))
    else $error("counter moved while disabled");
  a_count_step: assert property (
    ctrl_r.countdown_enable && tick_r && !restart && !expire
      |=> count_r == $past(count_r) - 24'h000001)
    else $error("counter did not step by one");
  a_restart_load: assert property (
    wr_count |=> count_r == $past(reload_r))
    else $error("counter write did not reload");
  a_expire_load: assert property (
    expire |=> count_r == $past(reload_r))
    else $error("no reload on expiry");
  a_reload_byte: assert property (
    io_req.wr && io_req.addr == `LWDT_OFF_RELOAD_LOW
      |=> reload_r[7:0] == $past(io_req.wdata))
    else $error("reload low byte not stored");
  a_read_count: assert property (
    io_req.rd && io_req.addr == `LWDT_OFF_COUNT_LOW
      |=> io_rdata == $past(count_r[7:0]))
    else $error("counter low byte read wrong");
  a_ctrl_off: assert property (
    $fell(rst) |-> !ctrl_r.countdown_enable)
    else $error("counting on after reset");

  // ==========================================================================
  // Flag checks
  a_first_sets: assert property (
    set_first |=> first_flag_r && irq)
    else $error("first expiry lost");
  a_first_clear: assert property (
    wr_flags && io_req.wdata[`LWDT_BIT_FIRST] && !set_first
      |=> !first_flag_r)
    else $error("first flag not cleared by one");
  a_first_keep: assert property (
    first_flag_r && !clr_first |=> first_flag_r)
    else $error("first flag dropped");
  a_clear_first: assert property (
    port80_wr && port80_en && !set_first |=> !first_flag_r)
    else $error("port 80h did not clear");
  a_second_needs: assert property (
    $rose(second_flag_r) |-> $past(first_flag_r))
    else $error("second flag without first");
  a_second_clear: assert property (
    clr_second && !set_second |=> !second_flag_r)
    else $error("second flag not cleared by one");
  a_set_wins: assert property (
    set_second |=> second_flag_r)
    else $error("second expiry lost");
  a_zero_keep: assert property (
    wr_flags && !io_req.wdata[`LWDT_BIT_SECOND] && second_flag_r
      |=> second_flag_r)
    else $error("second flag cleared by zero");

  // ==========================================================================
  // Interrupt and reset pulse checks
  a_irq_cause: assert property (
    irq |-> $past(set_first) || $past(set_second))
    else $error("stray interrupt");
  a_second_irq: assert property (
    set_second && !ctrl_r.module_reset_enable |=> irq)
    else $error("second interrupt missing");
  a_irq_single: assert property (
    irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_reset_fires: assert property (
    set_second && ctrl_r.module_reset_enable |=> module_rst)
    else $error("module reset missing");
  a_reset_gated: assert property (
    module_rst |-> $past(ctrl_r.module_reset_enable))
    else $error("reset while disabled");
  a_rst_single: assert property (
    module_rst |=> !module_rst)
    else $error("module reset longer than one cycle");
  a_pulse_apart: assert property (
    !(irq && module_rst))
    else $error("interrupt and reset together");

  // ==========================================================================
  // Main scenarios
  c_first: cover property (set_first);
  c_second: cover property (set_second);
  c_modrst: cover property (module_rst);
  c_restart80: cover property (port80_wr && port80_en);
  c_second_irq: cover property (set_second && !ctrl_r.module_reset_enable);

endmodule : lwdt_core

//--- core/lwdt_params.svh
// Watchdog register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the watchdog package or design file.
`ifndef LWDT_PARAMS_SVH
`define LWDT_PARAMS_SVH

// ==========================================================================
// Register offsets (byte-wide I/O space)
`define LWDT_OFF_COUNT_LOW 3'h0
`define LWDT_OFF_COUNT_MID 3'h1
`define LWDT_OFF_COUNT_HIGH 3'h2
`define LWDT_OFF_RELOAD_LOW 3'h3
`define LWDT_OFF_RELOAD_MID 3'h4
`define LWDT_OFF_RELOAD_HIGH 3'h5
`define LWDT_OFF_FLAGS 3'h6
`define LWDT_OFF_CONTROL 3'h7

// ==========================================================================
// Field positions
`define LWDT_BIT_FIRST 0
`define LWDT_BIT_SECOND 2
`define LWDT_BIT_RST_EN 0
`define LWDT_BIT_CNT_EN 1

// ==========================================================================
// Reset values
`define LWDT_RST_COUNT 24'h000000
`define LWDT_RST_RELOAD 24'h000000
`define LWDT_RST_CTRL 2'h0

// ==========================================================================
// Timing: tick rate and clock rate in Hz, divider in clocks
`define LWDT_TICK_HZ 32768
`define LWDT_CLK_HZ 50000000
`define LWDT_TICK_DIV (`LWDT_CLK_HZ / `LWDT_TICK_HZ)

`endif

//--- core/lwdt_pkg.sv
// Types shared by the watchdog block.
// Assumes the params header sits beside it.
package lwdt_pkg;

  // ==========================================================================
  // Host I/O request bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } lwdt_io_req_t;

  // ==========================================================================
  // Control register fields
  typedef struct packed {
    logic countdown_enable;
    logic module_reset_enable;
  } lwdt_ctrl_t;

endpackage : lwdt_pkg

//--- tb/lwdt_core_test.sv
// Self-checking bench for the watchdog core through its I/O registers.
// Assumes a 50 MHz clock, so one count of the timer is 1525 clocks.
`timescale 1ns/1ps

module lwdt_core_test;
  localparam int TICK = 1525;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lwdt_pkg::lwdt_io_req_t io_req;
  logic port80_wr;
  logic port80_en;
  logic [7:0] io_rdata;
  logic irq;
  logic module_rst;
  int n_fail = 0;
  int total_checks = 0;
  int gap;

  // ==========================================================================
  // Clock, reset, instances
  always #10 clk = ~clk;

  lwdt_core lwdt_core_inst (.clk(clk), .rst(rst), .io_req(io_req),
    .port80_wr(port80_wr), .port80_en(port80_en), .io_rdata(io_rdata),
    .irq(irq), .module_rst(module_rst));

  lwdt_host lwdt_host_inst (.clk(clk), .io_req(io_req),
    .port80_wr(port80_wr), .port80_en(port80_en), .io_rdata(io_rdata));

  // ==========================================================================
  // Compare and helper tasks
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check_int(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_int

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    lwdt_host_inst.rd(a, d);
    check8($sformatf("register %0d", a), exp, d);
  endtask : rd_chk

  // Cycles until the next pulse, -1 when none comes in time
  task automatic wait_pulse(input bit want_rst, output int n);
    n = -1;
    for (int i = 1; i <= 7000; i++) begin
      @(posedge clk);
      #1;
      if ((want_rst ? module_rst : irq) === 1'b1) begin
        n = i;
        break;
      end
    end
  endtask : wait_pulse

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Watchdog for a hung run
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
    lwdt_host_inst.wr(3'h3, 8'h5a);
    lwdt_host_inst.wr(3'h4, 8'ha5);
    lwdt_host_inst.wr(3'h5, 8'h3c);
    rd_chk(3'h3, 8'h5a);
    rd_chk(3'h4, 8'ha5);
    rd_chk(3'h5, 8'h3c);
    lwdt_host_inst.wr(3'h0, 8'hff);
    rd_chk(3'h0, 8'h5a);
    rd_chk(3'h1, 8'ha5);
    rd_chk(3'h2, 8'h3c);
    // Short reload so each expiry takes two counts
    lwdt_host_inst.wr(3'h3, 8'h02);
    lwdt_host_inst.wr(3'h4, 8'h00);
    lwdt_host_inst.wr(3'h5, 8'h00);
    lwdt_host_inst.wr(3'h2, 8'h00);
    rd_chk(3'h2, 8'h00);
    repeat (2 * TICK + 50) @(posedge clk);
    rd_chk(3'h0, 8'h02);
    lwdt_host_inst.wr(3'h7, 8'h02);
    rd_chk(3'h7, 8'h02);
    wait_pulse(1'b0, gap);
    check_int("first expiry seen", 1, int'(gap > 0));
    wait_pulse(1'b0, gap);
    check_int("expiry spacing", 2 * TICK, gap);
    rd_chk(3'h6, 8'h05);
    lwdt_host_inst.wr(3'h6, 8'h00);
    rd_chk(3'h6, 8'h05);
    lwdt_host_inst.wr(3'h6, 8'h04);
    rd_chk(3'h6, 8'h01);
    lwdt_host_inst.wr(3'h6, 8'h01);
    rd_chk(3'h6, 8'h00);
    // Port 80h option clears the first flag and restarts the count
    lwdt_host_inst.set80(1'b1);
    wait_pulse(1'b0, gap);
    rd_chk(3'h6, 8'h01);
    // Let one count pass so the restart shows in the counter
    repeat (TICK) @(posedge clk);
    rd_chk(3'h0, 8'h01);
    lwdt_host_inst.ping();
    rd_chk(3'h6, 8'h00);
    rd_chk(3'h0, 8'h02);
    lwdt_host_inst.wr(3'h7, 8'h03);
    rd_chk(3'h7, 8'h03);
    wait_pulse(1'b0, gap);
    wait_pulse(1'b1, gap);
    check_int("reset spacing", 2 * TICK, gap);
    stop_test();
  end
endmodule : lwdt_core_test

//--- tb/lwdt_host.sv
// Host side model: issues byte-wide I/O cycles and port 80h strobes.
// Assumes one clock shared with the watchdog and a caller that serialises.
`timescale 1ns/1ps

module lwdt_host (
  input wire logic clk,
  output lwdt_pkg::lwdt_io_req_t io_req,
  output logic port80_wr,
  output logic port80_en,
  input wire logic [7:0] io_rdata
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    io_req = '0;
    port80_wr = 1'b0;
    port80_en = 1'b0;
  end

  // ==========================================================================
  // Bus cycles; one idle edge between requests keeps strobes clean
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io_req <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    io_req <= '0;
    @(posedge clk);
    #1;
    d = io_rdata;
  endtask : rd

  // Kick through port 80h instead of the counter register
  task automatic ping();
    @(posedge clk);
    port80_wr <= 1'b1;
    @(posedge clk);
    port80_wr <= 1'b0;
  endtask : ping

  // Setup option that lets port 80h restart and clear
  task automatic set80(input logic v);
    @(posedge clk);
    port80_en <= v;
  endtask : set80
endmodule : lwdt_host
